// File: verilog/nvmc_map.vh
// Purpose: Register offsets, field positions, reset values and timing for the NVM controller.
// Assumes: Byte-wide register port, 200 MHz mclk.
// Notes:   Included by the controller; definitions only.
`ifndef NVMC_MAP_VH
`define NVMC_MAP_VH
`define NVMC_A_CTRL      5'h00
`define NVMC_A_EE_ADRL   5'h01
`define NVMC_A_EE_ADRH   5'h02
`define NVMC_A_EE_DATA   5'h03
`define NVMC_A_STATUS    5'h04
`define NVMC_A_IMASK     5'h05
`define NVMC_A_FL_ADRL   5'h06
`define NVMC_A_FL_ADRH   5'h07
`define NVMC_A_FL_DATA   5'h08
`define NVMC_A_FL_CMD    5'h09
`define NVMC_A_BUF_IDX   5'h0A
`define NVMC_A_BUF_DATA  5'h0B
`define NVMC_A_SEC_IDX   5'h0C
`define NVMC_A_SEC_DATA  5'h0D
`define NVMC_A_BUSY      5'h0E
`define NVMC_EE_BYTE_RD  3'h0
`define NVMC_EE_BYTE_WR  3'h1
`define NVMC_EE_ROW      3'h2
`define NVMC_EE_SECTOR   3'h3
`define NVMC_FL_BYTE_RD  3'h0
`define NVMC_FL_BYTE_WR  3'h1
`define NVMC_FL_BYTE_ER  3'h2
`define NVMC_FL_PAGE_ER  3'h3
`define NVMC_FL_SECT_ER  3'h4
`define NVMC_FL_CHIP_ER  3'h5
`define NVMC_FL_PAGE_PG  3'h6
`define NVMC_ST_DONE     0
`define NVMC_ST_ERR_LO   1
`define NVMC_ST_ERR_HI   2
`define NVMC_ST_FL_DONE  3
`define NVMC_EE_SIZE     512
`define NVMC_ROW_SIZE    64
`define NVMC_FL_SIZE     8192
`define NVMC_ERASED      8'h00
`define NVMC_FL_ERASED   8'hFF
`define NVMC_SEC_RESET   8'h00
`define NVMC_OP_MS       2
`define NVMC_CLK_MHZ     200
`define NVMC_OP_CYCLES   (`NVMC_OP_MS * `NVMC_CLK_MHZ * 1000)
`endif

// File: verilog/nvmc_ctrl.v
// Purpose: Data EEPROM and program flash controller behind a byte-wide register port.
// Assumes: Single clock mclk, asynchronous active-low nrst, brownout level from a pin.
// Notes:   Arrays are modelled as registers; every program or erase not blocked by a brownout runs a fixed timer.
//
// The implementer's own choices: the address map and the strobed register port.
`include "nvmc_map.vh"
`timescale 1ns/100ps
module nvmc_ctrl #(
    parameter OP_CYCLES = `NVMC_OP_CYCLES
) (
    // Clock and reset.
    input  wire        mclk,
    input  wire        nrst,
    // Register port.
    input  wire [4:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // Supply monitor pin.
    input  wire        nvm_brownout_trip,
    // Status and interrupt.
    output wire        busy,
    output wire        irq,
    output wire [63:0] sector_security
);

    // Register map, as software sees it over the byte-wide port.
    // Offset 00 takes an EEPROM command and starts it when the controller is idle.
    // Offsets 01 and 02 hold the EEPROM address, low byte and the top bit.
    // Offset 03 holds the EEPROM data: the value to write or fill, or the read result.
    // Offset 04 is the status register; each bit is sticky and cleared by writing a one.
    // Offset 05 is the interrupt mask, with the same layout as the status register.
    // Offsets 06 and 07 hold the flash address, low byte and the upper five bits.
    // Offset 08 holds the flash data: the value to write, or the read result.
    // Offset 09 takes a flash command and starts it when the controller is idle.
    // Offset 0A selects the page buffer entry that the next buffer write fills.
    // Offset 0B writes one page buffer entry, marks it and steps the index on.
    // Offset 0C selects which sector security byte offset 0D reaches.
    // Offset 0D reads or writes the selected sector security byte.
    // Offset 0E shows the busy state in bit 0 and is read only.
    // Any other offset reads as zero and ignores writes.
    //
    // Status bits.
    // Bit 0 is the EEPROM done flag, set as every EEPROM command finishes.
    // Bit 1 is the low write error flag, set when a brownout blocks an EEPROM write.
    // Bit 2 is the high write error flag, set together with bit 1.
    // Bit 3 is the flash done flag, set as every flash command finishes.
    // The interrupt output is high while any status bit is set and its mask bit is one.
    // When hardware sets a bit in the same cycle that software clears it, the set wins.
    // This way an event that lands on the clearing write is never lost.
    //
    // EEPROM commands.
    // Code 0 reads one byte into the data register in the very next cycle.
    // Code 1 writes the data register into the one addressed byte.
    // Code 2 writes the data register into all 64 bytes of the addressed row.
    // Code 3 writes the data register into all 512 bytes of the array.
    // Erasing a row or the array is simply a fill with the value zero.
    // Codes 4 to 7 run the timer and leave the array alone.
    //
    // Flash commands.
    // Code 0 reads one byte into the flash data register in the very next cycle.
    // Code 1 writes the flash data register into the one addressed byte.
    // Code 2 erases the addressed byte to the erased value.
    // Code 3 erases the 64-byte page that holds the flash address.
    // Code 4 erases the 1 kB sector that holds the flash address.
    // Code 5 erases the whole program flash.
    // Code 6 copies every marked page buffer entry into the addressed page.
    // After a page program all marks are cleared, ready for the next page.
    // Entries that were not marked keep their old contents in flash.
    // Code 7 runs the timer and leaves the array alone.
    //
    // Timing.
    // Reads finish in one cycle and never show busy.
    // Every program or erase not blocked by a brownout holds busy for OP_CYCLES cycles, counted inside.
    // The default count gives 2 ms at the 200 MHz clock.
    // Software only starts an operation; it never times any step itself.
    // The array changes, the done flag rises and busy falls at the same edge.
    // A command written while busy is dropped, not queued.
    // Software must poll busy or wait for the done flag before the next command.
    // Page buffer writes are also dropped while busy, so a running page program
    // never sees its data change underneath it.
    //
    // Brownout.
    // The detector pin passes a two-flop synchroniser before any logic reads it.
    // A trip therefore takes effect two cycles after it appears on the pin.
    // A program, fill or erase started while tripped never runs the timer.
    // For the EEPROM it sets the done flag and both write error flags at once.
    // For flash it sets only the flash done flag and leaves the array unchanged.
    // Reads still work while tripped, since they do not stress the cells.
    // A trip that appears once an operation is already running does not cut it.
    //
    // Security bytes.
    // Eight bytes, one per flash sector, are stored and shown on a flat port.
    // Byte n sits on bits 8n+7 to 8n of that port.
    // Enforcing the protection is left to the fetch logic that reads them.
    //
    // Reset.
    // All registers except the page buffer data clear to zero, security bytes included.
    // The arrays are not reset; their contents survive and start unknown.
    // Software must fill or erase before it relies on any location.
    //
    // Read data.
    // The read data register is loaded at the edge that samples the read strobe.
    // It stands for the one following cycle and then returns to zero.
    // Reading has no side effects on any register or flag.
    //
    // Limitations.
    // There is one timer, shared by the EEPROM and flash paths.
    // Only one operation of either kind can run at a time.
    // The page buffer index wraps from 63 back to 0 without warning.
    // The EEPROM address top bit lives in bit 0 of its high register.
    // The flash address upper bits live in bits 4 to 0 of its high register.
    // Unused upper bits of those registers read as zero.
    //
    // Hazards avoided.
    // Start requests are refused while busy so a second command cannot
    // overwrite the command of one in flight; its address and data registers stay writable.
    // The brownout level is never read before it is synchronised, so a
    // pin that changes near a clock edge cannot split the decision.
    // Fill loops write every location at one edge, so no partial row or
    // sector is ever visible to a read.
    //
    // State machine.
    // The idle state decodes the start write and either finishes a read,
    // records a blocked command, or loads the timer and moves on.
    // The EEPROM state counts down and then applies the EEPROM command.
    // The flash state counts down and then applies the flash command.
    // Any unused state code falls back to idle.
    //
    // Sizes.
    // The EEPROM holds 512 bytes in eight rows of 64 bytes.
    // The flash holds 8 kB in eight 1 kB sectors of sixteen 64-byte pages.
    // The page buffer holds 64 bytes with one mark bit per entry.
    // The timer is 32 bits wide, enough for the full 2 ms count.
    localparam ST_IDLE = 2'h0;
    localparam ST_EE   = 2'h1;
    localparam ST_FL   = 2'h2;

    reg [7:0]  ee_mem [0:`NVMC_EE_SIZE-1];
    reg [7:0]  fl_mem [0:`NVMC_FL_SIZE-1];
    reg [7:0]  page_buf [0:`NVMC_ROW_SIZE-1];
    reg [63:0] page_mask;
    reg [7:0]  sec_byte [0:7];
    reg [1:0]  state;
    reg [31:0] timer;
    reg [2:0]  op_cmd;
    reg [8:0]  ee_addr;
    reg [7:0]  ee_data;
    reg [12:0] fl_addr;
    reg [7:0]  fl_data;
    reg [5:0]  buf_idx;
    reg [2:0]  sec_idx;
    reg [3:0]  status;
    reg [3:0]  imask;
    reg        trip_s1;
    reg        trip;
    reg        ee_start;
    reg        fl_start;
    integer    i;

    // Brownout pin passes two flops before use.
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            trip_s1 <= 1'b0;
            trip    <= 1'b0;
        end else begin
            trip_s1 <= nvm_brownout_trip;
            trip    <= trip_s1;
        end
    end

    assign busy = (state != ST_IDLE);
    assign irq  = |(status & imask);

    // Security bytes are presented flat for the fetch logic.
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_sec
            assign sector_security[g*8 +: 8] = sec_byte[g];
        end
    endgenerate

    // Start requests come from writes to the command registers while idle.
    always @* begin
        ee_start = reg_wr && (reg_addr == `NVMC_A_CTRL) && !busy;
        fl_start = reg_wr && (reg_addr == `NVMC_A_FL_CMD) && !busy;
    end

    // Register writes, operation sequencing and flag handling.
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state     <= ST_IDLE;
            timer     <= 32'h0;
            op_cmd    <= 3'h0;
            ee_addr   <= 9'h000;
            ee_data   <= 8'h00;
            fl_addr   <= 13'h0000;
            fl_data   <= 8'h00;
            buf_idx   <= 6'h00;
            sec_idx   <= 3'h0;
            status    <= 4'h0;
            imask     <= 4'h0;
            page_mask <= 64'h0;
            for (i = 0; i < 8; i = i + 1) begin
                sec_byte[i] <= `NVMC_SEC_RESET;
            end
        end else begin
            // Software clears status by writing ones; a set in the same cycle wins.
            if (reg_wr && reg_addr == `NVMC_A_STATUS) begin
                status <= status & ~reg_wdata[3:0];
            end
            if (reg_wr) begin
                case (reg_addr)
                    `NVMC_A_EE_ADRL: ee_addr[7:0] <= reg_wdata;
                    `NVMC_A_EE_ADRH: ee_addr[8]   <= reg_wdata[0];
                    `NVMC_A_EE_DATA: ee_data      <= reg_wdata;
                    `NVMC_A_IMASK:   imask        <= reg_wdata[3:0];
                    `NVMC_A_FL_ADRL: fl_addr[7:0] <= reg_wdata;
                    `NVMC_A_FL_ADRH: fl_addr[12:8] <= reg_wdata[4:0];
                    `NVMC_A_FL_DATA: fl_data      <= reg_wdata;
                    `NVMC_A_BUF_IDX: buf_idx      <= reg_wdata[5:0];
                    `NVMC_A_BUF_DATA: begin
                        if (!busy) begin
                            page_buf[buf_idx]  <= reg_wdata;
                            page_mask[buf_idx] <= 1'b1;
                            buf_idx            <= buf_idx + 6'h01;
                        end
                    end
                    `NVMC_A_SEC_IDX:  sec_idx <= reg_wdata[2:0];
                    `NVMC_A_SEC_DATA: sec_byte[sec_idx] <= reg_wdata;
                    default: ;
                endcase
            end
            case (state)
                ST_IDLE: begin
                    if (ee_start) begin
                        op_cmd <= reg_wdata[2:0];
                        if (reg_wdata[2:0] == `NVMC_EE_BYTE_RD) begin
                            ee_data <= ee_mem[ee_addr];
                            status[`NVMC_ST_DONE] <= 1'b1;
                        end else if (trip) begin
                            status[`NVMC_ST_ERR_LO] <= 1'b1;
                            status[`NVMC_ST_ERR_HI] <= 1'b1;
                            status[`NVMC_ST_DONE]   <= 1'b1;
                        end else begin
                            timer <= OP_CYCLES - 1;
                            state <= ST_EE;
                        end
                    end else if (fl_start) begin
                        op_cmd <= reg_wdata[2:0];
                        if (reg_wdata[2:0] == `NVMC_FL_BYTE_RD) begin
                            fl_data <= fl_mem[fl_addr];
                            status[`NVMC_ST_FL_DONE] <= 1'b1;
                        end else if (trip) begin
                            status[`NVMC_ST_FL_DONE] <= 1'b1;
                        end else begin
                            timer <= OP_CYCLES - 1;
                            state <= ST_FL;
                        end
                    end
                end
                ST_EE: begin
                    if (timer == 32'h0) begin
                        case (op_cmd)
                            `NVMC_EE_BYTE_WR: ee_mem[ee_addr] <= ee_data;
                            `NVMC_EE_ROW: begin
                                for (i = 0; i < `NVMC_ROW_SIZE; i = i + 1) begin
                                    ee_mem[{ee_addr[8:6], i[5:0]}] <= ee_data;
                                end
                            end
                            `NVMC_EE_SECTOR: begin
                                for (i = 0; i < `NVMC_EE_SIZE; i = i + 1) begin
                                    ee_mem[i] <= ee_data;
                                end
                            end
                            default: ;
                        endcase
                        status[`NVMC_ST_DONE] <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        timer <= timer - 32'h1;
                    end
                end
                ST_FL: begin
                    if (timer == 32'h0) begin
                        case (op_cmd)
                            `NVMC_FL_BYTE_WR: fl_mem[fl_addr] <= fl_data;
                            `NVMC_FL_BYTE_ER: fl_mem[fl_addr] <= `NVMC_FL_ERASED;
                            `NVMC_FL_PAGE_ER: begin
                                for (i = 0; i < `NVMC_ROW_SIZE; i = i + 1) begin
                                    fl_mem[{fl_addr[12:6], i[5:0]}] <= `NVMC_FL_ERASED;
                                end
                            end
                            `NVMC_FL_SECT_ER: begin
                                for (i = 0; i < 1024; i = i + 1) begin
                                    fl_mem[{fl_addr[12:10], i[9:0]}] <= `NVMC_FL_ERASED;
                                end
                            end
                            `NVMC_FL_CHIP_ER: begin
                                for (i = 0; i < `NVMC_FL_SIZE; i = i + 1) begin
                                    fl_mem[i] <= `NVMC_FL_ERASED;
                                end
                            end
                            `NVMC_FL_PAGE_PG: begin
                                for (i = 0; i < `NVMC_ROW_SIZE; i = i + 1) begin
                                    if (page_mask[i]) begin
                                        fl_mem[{fl_addr[12:6], i[5:0]}] <= page_buf[i];
                                    end
                                end
                                page_mask <= 64'h0;
                            end
                            default: ;
                        endcase
                        status[`NVMC_ST_FL_DONE] <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        timer <= timer - 32'h1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Read data stands in the cycle after the read strobe.
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `NVMC_A_EE_ADRL: reg_rdata <= ee_addr[7:0];
                `NVMC_A_EE_ADRH: reg_rdata <= {7'h00, ee_addr[8]};
                `NVMC_A_EE_DATA: reg_rdata <= ee_data;
                `NVMC_A_STATUS:  reg_rdata <= {4'h0, status};
                `NVMC_A_IMASK:   reg_rdata <= {4'h0, imask};
                `NVMC_A_FL_ADRL: reg_rdata <= fl_addr[7:0];
                `NVMC_A_FL_ADRH: reg_rdata <= {3'h0, fl_addr[12:8]};
                `NVMC_A_FL_DATA: reg_rdata <= fl_data;
                `NVMC_A_BUF_IDX: reg_rdata <= {2'h0, buf_idx};
                `NVMC_A_SEC_IDX: reg_rdata <= {5'h00, sec_idx};
                `NVMC_A_SEC_DATA: reg_rdata <= sec_byte[sec_idx];
                `NVMC_A_BUSY:    reg_rdata <= {7'h00, busy};
                default:         reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// File: testbench/nvmc_ctrl_properties.sv
// Purpose: Concurrent checks on the NVM controller ports.
// Assumes: One clock domain; brownout held steady for three samples before use.
// Notes:   Bound to every nvmc_ctrl instance.
`timescale 1ns/100ps
module nvmc_ctrl_properties #(
    parameter OP_CYCLES = 8
) (
    // Clock and reset.
    input wire        mclk,
    input wire        nrst,
    // Register port.
    input wire [4:0]  reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [7:0]  reg_rdata,
    // Supply, status and security.
    input wire        nvm_brownout_trip,
    input wire        busy,
    input wire        irq,
    input wire [63:0] sector_security
);
    reg  [31:0] busy_len;
    wire        ee_go;
    wire        fl_go;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Command writes that would start a timed program or erase.
    assign ee_go = reg_wr && reg_addr == 5'h00 && reg_wdata >= 8'h01 && reg_wdata <= 8'h03 && !busy;
    assign fl_go = reg_wr && reg_addr == 5'h09 && reg_wdata >= 8'h01 && reg_wdata <= 8'h06 && !busy;
    // Counts how long busy has been high without a break.
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy_len <= 32'h0;
        end else begin
            busy_len <= busy ? busy_len + 32'h1 : 32'h0;
        end
    end
    property p_op_len; $fell(busy) |-> busy_len == OP_CYCLES; endproperty
    a_op_len: assert property (p_op_len) else $error("busy length wrong");
    property p_ee_start; !nvm_brownout_trip [*3] ##0 ee_go |=> busy; endproperty
    a_ee_start: assert property (p_ee_start) else $error("eeprom op did not start");
    property p_ee_block; nvm_brownout_trip [*3] ##0 ee_go |=> !busy; endproperty
    a_ee_block: assert property (p_ee_block) else $error("eeprom op not blocked");
    property p_fl_block; nvm_brownout_trip [*3] ##0 fl_go |=> !busy [*2]; endproperty
    a_fl_block: assert property (p_fl_block) else $error("flash op not blocked");
    property p_irq_hold; irq && !(reg_wr && (reg_addr == 5'h04 || reg_addr == 5'h05)) |=> irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped alone");
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_busy_reg; reg_rd && reg_addr == 5'h0E |=> reg_rdata == {7'h00, $past(busy)};
    endproperty
    a_busy_reg: assert property (p_busy_reg) else $error("busy register wrong");
    property p_sec; !$stable(sector_security) |-> $past(reg_wr && reg_addr == 5'h0D); endproperty
    a_sec: assert property (p_sec) else $error("security byte changed alone");
    c_op: cover property ($fell(busy));
    c_irq: cover property ($rose(irq));
    c_block: cover property (nvm_brownout_trip && ee_go);
endmodule
bind nvmc_ctrl nvmc_ctrl_properties #(.OP_CYCLES(OP_CYCLES)) u_props (.mclk(mclk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .nvm_brownout_trip(nvm_brownout_trip), .busy(busy), .irq(irq),
    .sector_security(sector_security));

// File: testbench/test_nonvolatile_memory_controller.sv
// Purpose: Directed register-level regression of the NVM controller.
// Assumes: Shortened timer, so each program or erase not blocked by a brownout takes OP cycles.
// Notes:   Arrays start unknown, so each test fills before it reads back.
`timescale 1ns/100ps
module test_nonvolatile_memory_controller;
    localparam OP = 8;
    reg         mclk;
    reg         nrst;
    reg  [4:0]  reg_addr;
    reg  [7:0]  reg_wdata;
    reg         reg_wr;
    reg         reg_rd;
    reg         trip;
    wire [7:0]  reg_rdata;
    wire        busy;
    wire        irq;
    wire [63:0] sec;
    integer     n_errors;
    integer     cmp_count;
    // Device with a short operation timer.
    nvmc_ctrl #(.OP_CYCLES(OP)) u_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .nvm_brownout_trip(trip), .busy(busy), .irq(irq), .sector_security(sec));
    // Free-running 200 MHz clock.
    always #2.5 mclk = ~mclk;
    // Counts a comparison and reports a mismatch.
    task chk(input string what, input [7:0] exp, input [7:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // Register write; the strobe drops one edge later.
    task wr(input [4:0] a, input [7:0] d);
        begin
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge mclk);
            reg_wr <= 1'b0;
            @(posedge mclk);
        end
    endtask
    // Register read; data is looked at in its one valid cycle.
    task rd(input [4:0] a, input [7:0] exp, input string what);
        begin
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge mclk);
            reg_rd <= 1'b0;
            @(negedge mclk);
            chk(what, exp, reg_rdata);
            @(posedge mclk);
        end
    endtask
    // Issues a command and waits a bounded time for busy to drop.
    task op(input [4:0] a, input [7:0] c, input bz);
        integer n;
        begin
            wr(a, c);
            chk("busy", {7'h00, bz}, {7'h00, busy});
            for (n = 0; n < OP + 4 && busy !== 1'b0; n = n + 1) begin
                @(negedge mclk);
            end
            chk("busy_end", 8'h00, {7'h00, busy});
            @(posedge mclk);
        end
    endtask
    task ee(input [8:0] a, input [7:0] d, input [7:0] c, input bz);
        begin
            wr(5'h01, a[7:0]);
            wr(5'h02, {7'h00, a[8]});
            wr(5'h03, d);
            op(5'h00, c, bz);
        end
    endtask
    task ee_rd(input [8:0] a, input [7:0] exp);
        begin
            ee(a, 8'h00, 8'h00, 1'b0);
            rd(5'h03, exp, "ee_data");
        end
    endtask
    task fl(input [12:0] a, input [7:0] d, input [7:0] c, input bz);
        begin
            wr(5'h06, a[7:0]);
            wr(5'h07, {3'h0, a[12:8]});
            wr(5'h08, d);
            op(5'h09, c, bz);
        end
    endtask
    task fl_rd(input [12:0] a, input [7:0] exp);
        begin
            fl(a, 8'h00, 8'h00, 1'b0);
            rd(5'h08, exp, "fl_data");
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task complete_run;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
            if (n_errors == 0 && cmp_count > 0) begin
                $display("Regression OK");
            end else begin
                $display("Regression broken");
            end
            $finish;
        end
    endtask
    // Watchdog against a hung handshake.
    initial begin
        #100000;
        n_errors = n_errors + 1;
        complete_run;
    end
    // Main sequence.
    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        trip = 1'b0;
        n_errors = 0;
        cmp_count = 0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rd(5'h04, 8'h00, "status");
        rd(5'h1F, 8'h00, "unmapped");
        $display("test reset done");
        ee(9'h000, 8'h00, 8'h03, 1'b1);
        ee_rd(9'h1FF, 8'h00);
        ee(9'h045, 8'h3C, 8'h02, 1'b1);
        ee_rd(9'h040, 8'h3C);
        ee_rd(9'h07F, 8'h3C);
        ee_rd(9'h080, 8'h00);
        ee(9'h1FF, 8'hA5, 8'h01, 1'b1);
        ee_rd(9'h1FE, 8'h00);
        wr(5'h03, 8'h5A);
        wr(5'h00, 8'h01);
        op(5'h00, 8'h03, 1'b1);
        ee_rd(9'h1FE, 8'h5A);
        ee_rd(9'h1FF, 8'hA5);
        wr(5'h05, 8'h01);
        chk("irq", 8'h01, {7'h00, irq});
        repeat (4) @(posedge mclk);
        rd(5'h04, 8'h01, "status");
        wr(5'h04, 8'h01);
        chk("irq", 8'h00, {7'h00, irq});
        $display("test eeprom done");
        trip <= 1'b1;
        repeat (3) @(posedge mclk);
        ee(9'h000, 8'hFF, 8'h01, 1'b0);
        rd(5'h04, 8'h07, "status");
        wr(5'h04, 8'h07);
        ee_rd(9'h000, 8'h00);
        wr(5'h04, 8'h07);
        rd(5'h04, 8'h00, "status");
        fl(13'h0000, 8'h12, 8'h01, 1'b0);
        rd(5'h04, 8'h08, "status");
        trip <= 1'b0;
        repeat (3) @(posedge mclk);
        $display("test brownout done");
        fl(13'h0000, 8'h00, 8'h05, 1'b1);
        fl_rd(13'h1FFF, 8'hFF);
        fl(13'h0400, 8'h55, 8'h01, 1'b1);
        fl_rd(13'h0400, 8'h55);
        fl(13'h0400, 8'h00, 8'h02, 1'b1);
        fl_rd(13'h0400, 8'hFF);
        wr(5'h0A, 8'h02);
        wr(5'h0B, 8'h77);
        fl(13'h0440, 8'h00, 8'h06, 1'b1);
        fl_rd(13'h0442, 8'h77);
        fl_rd(13'h0441, 8'hFF);
        fl(13'h047F, 8'h00, 8'h03, 1'b1);
        fl_rd(13'h0442, 8'hFF);
        fl(13'h0000, 8'h99, 8'h01, 1'b1);
        fl(13'h03FF, 8'h00, 8'h04, 1'b1);
        fl_rd(13'h0000, 8'hFF);
        $display("test flash done");
        wr(5'h0C, 8'h07);
        wr(5'h0D, 8'h5A);
        chk("sec7", 8'h5A, sec[63:56]);
        chk("sec6", 8'h00, sec[55:48]);
        $display("test security done");
        complete_run;
    end
endmodule
